// *** hdl/uei_pkg.sv ***
// shared constants, register map and event carriers for the usb event block
package uei_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets on the apb bus)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_IRQ_ENABLE_FIRST = 8'h00;
    localparam logic [7:0] OFF_IRQ_FLAGS_SECOND = 8'h04;
    localparam logic [7:0] OFF_IRQ_ENABLE_SECOND = 8'h08;
    localparam logic [7:0] OFF_EP_DIR = 8'h0C;
    localparam logic [7:0] OFF_EP_STATUS_BASE = 8'h10;
    localparam logic [7:0] OFF_EP_RX_COUNT_BASE = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EP_RX_READY_BIT = 0;
    localparam int EP_TX_READY_BIT = 1;
    localparam int EN1_TX_SHIFT = 8;
    localparam int SOF_BIT = 0;
    localparam int BUS_RST_ON_BIT = 1;
    localparam int BUS_RST_OFF_BIT = 2;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int MAX_EP = 8;
    localparam int EP_IDX_W = 3;
    localparam int RX_CNT_W = 7;
    localparam int FLAGS2_W = 3;
    localparam logic [15:0] EN1_RESET = 16'h0000;
    localparam logic [2:0] FLAGS2_RESET = 3'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing: single-ended-zero length that marks a bus reset
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SE0_RESET_NS = 2500;
    localparam int SE0_RESET_CYC = (SE0_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SE0_CNT_W = 9;

    // ------------------------------------------------------------
    // carriers from the serial engine and the line
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic err;
        logic [EP_IDX_W-1:0] ep;
        logic [RX_CNT_W-1:0] count;
    } uei_rx_evt_t;

    typedef struct packed {
        logic valid;
        logic [EP_IDX_W-1:0] ep;
    } uei_tx_evt_t;

    typedef struct packed {
        logic dp;
        logic dm;
    } uei_line_t;

endpackage

// *** hdl/uei_top.sv ***
// endpoint, frame and bus reset event and interrupt logic with apb registers
// Contract
// - set endpoint receive-ready bit 0 when packet ended and stored without error.
// - end-of-packet completes reception for full and short packets alike.
// - receive-ready raises interrupt only when its enable bit is set.
// - writing one clears a ready flag; writing zero leaves it.
// - transmitter endpoint clears transmit-ready bit 1 when its buffer is free.
// - transmit-ready clear interrupts only when its first-enable bit is set.
// - later transmit interrupts wait for the host acknowledge of the last packet.
// - writing one to bit 1 arms the endpoint and drops its interrupt.
// - a short packet may be armed and is sent as loaded.
// - every received frame-start packet sets its second-status event.
// - frame-start and bus reset events clear on a written one.
// - line zero held 2.5 us or longer raises the reset-assert event.
// - return to J after such a long zero raises reset-deassert.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module uei_top import uei_pkg::*; #(
    parameter int NUM_EP = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire uei_rx_evt_t rx_evt,
    input wire uei_tx_evt_t tx_ack_evt,
    input wire logic sof_seen,
    input wire uei_line_t line,
    output logic [NUM_EP-1:0] tx_armed,
    output logic irq_out_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NUM_EP-1:0] rx_rdy_q, rx_rdy_d;
    logic [NUM_EP-1:0] tx_rdy_q, tx_rdy_d;
    logic [NUM_EP-1:0] tx_pend_q, tx_pend_d;
    logic [NUM_EP-1:0] tx_dir_q, tx_dir_d;
    logic [RX_CNT_W-1:0] rx_cnt_q [NUM_EP];
    logic [RX_CNT_W-1:0] rx_cnt_d [NUM_EP];
    logic [15:0] en1_q, en1_d;
    logic [FLAGS2_W-1:0] flags2_q, flags2_d;
    logic [FLAGS2_W-1:0] en2_q, en2_d;
    logic [SE0_CNT_W-1:0] se0_cnt_q, se0_cnt_d;
    logic in_rst_q, in_rst_d;
    logic [31:0] rdata_q, rdata_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // per-endpoint slot: {hit, index}
    function automatic logic [EP_IDX_W:0] slot_of(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] diff;
        diff = a - base;
        slot_of = {(a >= base) && (diff[7:2] < 6'(NUM_EP)) && (diff[1:0] == 2'b00),
                   diff[EP_IDX_W+1:2]};
    endfunction

    // endpoint number inside the configured range, safe for eight endpoints
    function automatic logic ep_ok(input logic [EP_IDX_W-1:0] ep);
        ep_ok = int'(ep) < NUM_EP;
    endfunction

    logic setup, wr;
    logic [EP_IDX_W:0] st_slot, cnt_slot;
    logic mapped;
    logic se0, line_j;
    logic rx_ok, tx_ack_ok;

    // bus phases and address hits
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign st_slot = slot_of(paddr, OFF_EP_STATUS_BASE);
    assign cnt_slot = slot_of(paddr, OFF_EP_RX_COUNT_BASE);
    assign mapped = (paddr == OFF_IRQ_ENABLE_FIRST) || (paddr == OFF_IRQ_FLAGS_SECOND)
                    || (paddr == OFF_IRQ_ENABLE_SECOND) || (paddr == OFF_EP_DIR)
                    || st_slot[EP_IDX_W] || cnt_slot[EP_IDX_W];
    assign pready = 1'b1; // zero-wait slave
    assign pslverr = psel && penable && !mapped;

    // line states seen on the differential pins
    assign se0 = !line.dp && !line.dm;
    assign line_j = line.dp && !line.dm;
    assign rx_ok = rx_evt.valid && !rx_evt.err && ep_ok(rx_evt.ep);
    assign tx_ack_ok = tx_ack_evt.valid && ep_ok(tx_ack_evt.ep);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // software writes first, hardware events after so a hardware event wins
    always_comb begin
        rx_rdy_d = rx_rdy_q;
        tx_rdy_d = tx_rdy_q;
        tx_pend_d = tx_pend_q;
        tx_dir_d = tx_dir_q;
        rx_cnt_d = rx_cnt_q;
        en1_d = en1_q;
        flags2_d = flags2_q;
        en2_d = en2_q;
        se0_cnt_d = se0_cnt_q;
        in_rst_d = in_rst_q;
        rdata_d = rdata_q;
        if (wr && mapped) begin
            if (paddr == OFF_IRQ_ENABLE_FIRST) begin
                en1_d = pwdata[15:0];
            end else if (paddr == OFF_IRQ_FLAGS_SECOND) begin
                flags2_d = flags2_q & ~pwdata[FLAGS2_W-1:0];
            end else if (paddr == OFF_IRQ_ENABLE_SECOND) begin
                en2_d = pwdata[FLAGS2_W-1:0];
            end else if (paddr == OFF_EP_DIR) begin
                tx_dir_d = pwdata[NUM_EP-1:0];
            end else if (st_slot[EP_IDX_W]) begin
                if (pwdata[EP_RX_READY_BIT]) begin
                    rx_rdy_d[st_slot[EP_IDX_W-1:0]] = 1'b0;
                end
                if (pwdata[EP_TX_READY_BIT]) begin
                    tx_rdy_d[st_slot[EP_IDX_W-1:0]] = 1'b1;
                    tx_pend_d[st_slot[EP_IDX_W-1:0]] = 1'b0;
                end
            end
        end
        // a packet stored cleanly at its end-of-packet, any length
        if (rx_ok) begin
            rx_rdy_d[rx_evt.ep] = 1'b1;
            rx_cnt_d[rx_evt.ep] = rx_evt.count;
        end
        // first packet: becoming a transmitter leaves the buffer free
        for (int i = 0; i < NUM_EP; i++) begin
            if (tx_dir_d[i] && !tx_dir_q[i]) begin
                tx_rdy_d[i] = 1'b0;
                tx_pend_d[i] = 1'b1;
            end
        end
        // later packets: free only once the host acknowledged
        if (tx_ack_ok && tx_dir_q[tx_ack_evt.ep]) begin
            tx_rdy_d[tx_ack_evt.ep] = 1'b0;
            tx_pend_d[tx_ack_evt.ep] = 1'b1;
        end
        if (sof_seen) begin
            flags2_d[SOF_BIT] = 1'b1;
        end
        // single-ended-zero run length, saturating
        if (se0) begin
            if (se0_cnt_q != SE0_CNT_W'(SE0_RESET_CYC)) begin
                se0_cnt_d = se0_cnt_q + SE0_CNT_W'(1);
            end
            if (se0_cnt_q == SE0_CNT_W'(SE0_RESET_CYC - 1)) begin
                flags2_d[BUS_RST_ON_BIT] = 1'b1;
                in_rst_d = 1'b1;
            end
        end else begin
            se0_cnt_d = '0;
        end
        if (in_rst_q && line_j) begin
            flags2_d[BUS_RST_OFF_BIT] = 1'b1;
            in_rst_d = 1'b0;
        end
        // read data captured in the setup cycle
        if (setup && !pwrite) begin
            rdata_d = RDATA_RESET;
            if (paddr == OFF_IRQ_ENABLE_FIRST) begin
                rdata_d[15:0] = en1_q;
            end else if (paddr == OFF_IRQ_FLAGS_SECOND) begin
                rdata_d[FLAGS2_W-1:0] = flags2_q;
            end else if (paddr == OFF_IRQ_ENABLE_SECOND) begin
                rdata_d[FLAGS2_W-1:0] = en2_q;
            end else if (paddr == OFF_EP_DIR) begin
                rdata_d[NUM_EP-1:0] = tx_dir_q;
            end else if (st_slot[EP_IDX_W]) begin
                rdata_d[EP_RX_READY_BIT] = rx_rdy_q[st_slot[EP_IDX_W-1:0]];
                rdata_d[EP_TX_READY_BIT] = tx_rdy_q[st_slot[EP_IDX_W-1:0]];
            end else if (cnt_slot[EP_IDX_W]) begin
                rdata_d[RX_CNT_W-1:0] = rx_cnt_q[cnt_slot[EP_IDX_W-1:0]];
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // state update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_rdy_q <= '0;
            tx_rdy_q <= '0;
            tx_pend_q <= '0;
            tx_dir_q <= '0;
            for (int i = 0; i < NUM_EP; i++) begin
                rx_cnt_q[i] <= '0;
            end
            en1_q <= EN1_RESET;
            flags2_q <= FLAGS2_RESET;
            en2_q <= FLAGS2_RESET;
            se0_cnt_q <= '0;
            in_rst_q <= 1'b0;
            rdata_q <= RDATA_RESET;
        end else begin
            rx_rdy_q <= rx_rdy_d;
            tx_rdy_q <= tx_rdy_d;
            tx_pend_q <= tx_pend_d;
            tx_dir_q <= tx_dir_d;
            rx_cnt_q <= rx_cnt_d;
            en1_q <= en1_d;
            flags2_q <= flags2_d;
            en2_q <= en2_d;
            se0_cnt_q <= se0_cnt_d;
            in_rst_q <= in_rst_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic irq_pending;

    // any enabled pending event pulls the interrupt low
    assign irq_pending = |(rx_rdy_q & en1_q[NUM_EP-1:0])
                         | |(tx_pend_q & tx_dir_q & en1_q[EN1_TX_SHIFT +: NUM_EP])
                         | |(flags2_q & en2_q);
    assign irq_out_n = !irq_pending;
    assign tx_armed = tx_rdy_q;
    assign prdata = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_st;
    logic [EP_IDX_W-1:0] wr_idx;
    assign wr_st = wr && st_slot[EP_IDX_W];
    assign wr_idx = st_slot[EP_IDX_W-1:0];

    // writes and events land where the rules put them
    AST_RX_SET: assert property (rx_ok |=> rx_rdy_q[$past(rx_evt.ep)]
        && rx_cnt_q[$past(rx_evt.ep)] == $past(rx_evt.count))
        else $error("receive ready not set after good packet");
    AST_RX_CLEAR: assert property (wr_st && pwdata[0] && !(rx_ok && rx_evt.ep == wr_idx)
        |=> !rx_rdy_q[$past(wr_idx)])
        else $error("receive ready not cleared by written one");
    AST_RX_KEEP: assert property (wr_st && !pwdata[0] && rx_rdy_q[wr_idx]
        |=> rx_rdy_q[$past(wr_idx)])
        else $error("receive ready lost on written zero");
    AST_TX_ARM: assert property (wr_st && pwdata[1] && !tx_ack_evt.valid
        && !(tx_dir_d[wr_idx] && !tx_dir_q[wr_idx])
        |=> tx_armed[$past(wr_idx)] && !tx_pend_q[$past(wr_idx)])
        else $error("endpoint not armed by written one");
    AST_TX_ACK: assert property (tx_ack_ok && tx_dir_q[tx_ack_evt.ep]
        |=> !tx_armed[$past(tx_ack_evt.ep)] && tx_pend_q[$past(tx_ack_evt.ep)])
        else $error("acknowledge did not free the transmit buffer");
    AST_TX_IRQ: assert property (tx_ack_ok && tx_dir_q[tx_ack_evt.ep]
        && en1_q[EN1_TX_SHIFT + int'(tx_ack_evt.ep)] && !wr |=> !irq_out_n)
        else $error("enabled transmit event gave no interrupt");
    AST_SOF: assert property (sof_seen && en2_q[SOF_BIT] && !wr
        |=> flags2_q[SOF_BIT] ##0 !irq_out_n)
        else $error("frame start event missing");
    AST_FLAG2_W1C: assert property (wr && paddr == OFF_IRQ_FLAGS_SECOND && pwdata[0]
        && !sof_seen |=> !flags2_q[SOF_BIT])
        else $error("frame start flag not cleared");
    AST_RST_ON: assert property ($rose(flags2_q[BUS_RST_ON_BIT])
        |-> $past(se0_cnt_q) == SE0_CNT_W'(SE0_RESET_CYC - 1) && $past(se0))
        else $error("reset assert raised without long zero");
    AST_RST_ON_DUE: assert property (se0 && se0_cnt_q == SE0_CNT_W'(SE0_RESET_CYC - 1)
        |=> flags2_q[BUS_RST_ON_BIT] && in_rst_q)
        else $error("reset assert missing after long zero");
    AST_RST_OFF: assert property (in_rst_q && line_j
        |=> flags2_q[BUS_RST_OFF_BIT] && !in_rst_q)
        else $error("reset deassert missing on return to J");
    AST_IRQ_QUIET: assert property (en1_q == 16'h0000 && en2_q == 3'h0 |-> irq_out_n)
        else $error("interrupt asserted with all enables off");

    // ------------------------------------------------------------
    // cross checks: refused events and quiet paths
    // ------------------------------------------------------------
    // receive ready rises only from a clean, in-range packet
    AST_RX_ONLY: assert property ((rx_rdy_q & ~$past(rx_rdy_q)) != '0 |-> $past(rx_ok))
        else $error("receive ready set without good packet");
    AST_RX_REFUSE: assert property (rx_evt.valid && !rx_ok && !wr
        |=> rx_rdy_q == $past(rx_rdy_q))
        else $error("refused packet changed receive ready");
    AST_RX_IRQ: assert property (rx_ok && en1_q[int'(rx_evt.ep)] && !wr |=> !irq_out_n)
        else $error("enabled receive event gave no interrupt");
    AST_CNT_RO: assert property (wr && cnt_slot[EP_IDX_W] && !rx_ok
        |=> rx_cnt_q[$past(cnt_slot[EP_IDX_W-1:0])] == $past(rx_cnt_q[cnt_slot[EP_IDX_W-1:0]]))
        else $error("byte count changed by a write");

    // transmit ready moves only on direction, arming or acknowledge
    AST_TX_FIRST: assert property (wr && paddr == OFF_EP_DIR
        |=> ((tx_dir_q & ~$past(tx_dir_q)) & (tx_armed | ~tx_pend_q)) == '0)
        else $error("new transmitter not freed for its first packet");
    AST_TX_KEEP: assert property (wr_st && !pwdata[1] && tx_armed[wr_idx]
        && !tx_ack_evt.valid |=> tx_armed[$past(wr_idx)])
        else $error("transmit ready lost on written zero");
    AST_TX_HOLD: assert property (!tx_ack_evt.valid && !wr
        |=> (tx_armed & $past(tx_armed)) == $past(tx_armed))
        else $error("armed endpoint freed without acknowledge");
    AST_TX_NOACK: assert property (tx_ack_evt.valid && !wr
        && !(tx_ack_ok && tx_dir_q[tx_ack_evt.ep]) |=> tx_armed == $past(tx_armed))
        else $error("stray acknowledge changed transmit ready");

    // second status bank and line states
    AST_SOF_ONLY: assert property ($rose(flags2_q[SOF_BIT]) |-> $past(sof_seen))
        else $error("frame start flag set without frame start");
    AST_SOF_ALWAYS: assert property (sof_seen |=> flags2_q[SOF_BIT])
        else $error("masked frame start not recorded");
    AST_FLAG2_KEEP: assert property (wr && paddr == OFF_IRQ_FLAGS_SECOND
        |=> ($past(flags2_q & ~pwdata[FLAGS2_W-1:0]) & ~flags2_q) == '0)
        else $error("second status bit lost on written zero");
    AST_RST_SHORT: assert property (se0 && se0_cnt_q < SE0_CNT_W'(SE0_RESET_CYC - 1)
        && !flags2_q[BUS_RST_ON_BIT] |=> !flags2_q[BUS_RST_ON_BIT])
        else $error("reset assert raised by a short zero");
    AST_RST_W1C: assert property (wr && paddr == OFF_IRQ_FLAGS_SECOND
        && pwdata[BUS_RST_ON_BIT] && !(se0 && se0_cnt_q == SE0_CNT_W'(SE0_RESET_CYC - 1))
        |=> !flags2_q[BUS_RST_ON_BIT])
        else $error("reset assert flag not cleared");
    AST_SE0_RUN: assert property (!se0 |=> se0_cnt_q == '0)
        else $error("zero run not restarted by a non-zero line");
    AST_RST_HOLD: assert property (in_rst_q && !line_j |=> in_rst_q)
        else $error("bus reset state left before J");
    AST_RST_OFF_ONLY: assert property ($rose(flags2_q[BUS_RST_OFF_BIT])
        |-> $past(in_rst_q) && $past(line_j))
        else $error("reset deassert raised outside bus reset");

    // interrupt low only while something is pending
    AST_IRQ_CAUSE: assert property (!irq_out_n
        |-> (rx_rdy_q | tx_pend_q) != '0 || flags2_q != '0)
        else $error("interrupt asserted with nothing pending");

    COV_RX_CYCLE: cover property (rx_ok ##[1:20] (wr_st && pwdata[0]));
    COV_TX_CYCLE: cover property ((wr_st && pwdata[1]) ##[1:50] tx_ack_ok);
    COV_BUS_RESET: cover property ($rose(in_rst_q) ##[1:100] $fell(in_rst_q));
    COV_SOF_IRQ: cover property (sof_seen && en2_q[SOF_BIT] ##1 !irq_out_n);
    // first-packet transmit interrupt right after a direction write
    COV_TX_FIRST_IRQ: cover property ((wr && paddr == OFF_EP_DIR) ##1 !irq_out_n);

endmodule

// *** tb/tb_uei_top.sv ***
// self-checking testbench for the usb event and interrupt block
module tb_uei_top;
    import uei_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    uei_rx_evt_t rx_evt;
    uei_tx_evt_t tx_ack_evt;
    logic sof_seen;
    uei_line_t line;
    logic [4:0] tx_armed;
    logic irq_out_n;
    logic [31:0] rv;
    logic se;
    int err_total = 0;
    int checked = 0;

    always #5 pclk = ~pclk;

    uei_top #(.NUM_EP(5)) i_uei_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .tx_ack_evt(tx_ack_evt),
        .sof_seen(sof_seen), .line(line), .tx_armed(tx_armed), .irq_out_n(irq_out_n));

    uei_usb_side_mdl i_uei_usb_side_mdl (.pclk(pclk), .rx_evt(rx_evt),
        .tx_ack_evt(tx_ack_evt), .sof_seen(sof_seen), .line(line));

    // --------------------------------------------------------
    // report and compare helpers
    // --------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // one apb transfer, then one idle cycle so strobes never toggle twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            give_verdict();
        end
        rv = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", rv, e);
    endtask

    task automatic ci(input logic e);
        chk("irq_out_n", {31'h0, irq_out_n}, {31'h0, e});
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ci(1'b1);
        chk("tx_armed", {27'h0, tx_armed}, 32'h0);
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0);
        rc(8'hfc, 32'h0);
        chk("pslverr", {31'h0, se}, 32'h1);
        // rx ready enabled on eps 0,2,3,4; tx ready enabled on ep1 only
        apb(1'b1, 8'h00, 32'h21d);
        i_uei_usb_side_mdl.send_rx(1'b0, 3'h1, 7'h05);
        rc(8'h14, 32'h1);
        ci(1'b1);
        apb(1'b1, 8'h14, 32'h1);
        i_uei_usb_side_mdl.send_rx(1'b1, 3'h2, 7'h05);
        rc(8'h18, 32'h0);
        ci(1'b1);
        i_uei_usb_side_mdl.send_rx(1'b0, 3'h2, 7'h05);
        rc(8'h18, 32'h1);
        rc(8'h38, 32'h5);
        ci(1'b0);
        i_uei_usb_side_mdl.send_rx(1'b0, 3'h2, 7'h40);
        rc(8'h38, 32'h40);
        apb(1'b1, 8'h38, 32'h0);
        rc(8'h38, 32'h40);
        apb(1'b1, 8'h18, 32'h0);
        rc(8'h18, 32'h1);
        apb(1'b1, 8'h18, 32'h1);
        rc(8'h18, 32'h0);
        ci(1'b1);
        // ep1 and ep3 become transmitters; only ep1 may interrupt
        apb(1'b1, 8'h0c, 32'ha);
        rc(8'h0c, 32'ha);
        rc(8'h14, 32'h0);
        ci(1'b0);
        apb(1'b1, 8'h14, 32'h2);
        chk("tx_armed", {27'h0, tx_armed}, 32'h2);
        ci(1'b1);
        rc(8'h14, 32'h2);
        repeat (20) @(posedge pclk);
        ci(1'b1);
        i_uei_usb_side_mdl.send_ack(3'h2);
        chk("tx_armed", {27'h0, tx_armed}, 32'h2);
        i_uei_usb_side_mdl.send_ack(3'h1);
        chk("tx_armed", {27'h0, tx_armed}, 32'h0);
        ci(1'b0);
        apb(1'b1, 8'h14, 32'h2);
        ci(1'b1);
        // frame start with and without its mask bit
        apb(1'b1, 8'h08, 32'h7);
        rc(8'h08, 32'h7);
        i_uei_usb_side_mdl.send_sof();
        rc(8'h04, 32'h1);
        ci(1'b0);
        apb(1'b1, 8'h04, 32'h1);
        rc(8'h04, 32'h0);
        ci(1'b1);
        apb(1'b1, 8'h08, 32'h6);
        i_uei_usb_side_mdl.send_sof();
        rc(8'h04, 32'h1);
        ci(1'b1);
        apb(1'b1, 8'h04, 32'h1);
        // single-ended zero one cycle short, then exactly long enough
        i_uei_usb_side_mdl.hold_line(1'b0, 1'b0, SE0_RESET_CYC - 1);
        i_uei_usb_side_mdl.hold_line(1'b1, 1'b0, 3);
        rc(8'h04, 32'h0);
        i_uei_usb_side_mdl.hold_line(1'b0, 1'b0, SE0_RESET_CYC);
        rc(8'h04, 32'h2);
        ci(1'b0);
        i_uei_usb_side_mdl.hold_line(1'b1, 1'b0, 3);
        rc(8'h04, 32'h6);
        apb(1'b1, 8'h04, 32'h6);
        rc(8'h04, 32'h0);
        ci(1'b1);
        give_verdict();
    end
endmodule

// *** tb/uei_usb_side_mdl.sv ***
// usb-side partner model: serial engine event pulses and line levels
module uei_usb_side_mdl import uei_pkg::*; (
    input wire logic pclk,
    output uei_rx_evt_t rx_evt,
    output uei_tx_evt_t tx_ack_evt,
    output logic sof_seen,
    output uei_line_t line
);
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------------------------------------
    // idle values: no events, line parked in J
    // --------------------------------------------------------
    initial begin
        rx_evt = '0;
        tx_ack_evt = '0;
        sof_seen = 1'b0;
        line = '{dp: 1'b1, dm: 1'b0};
    end

    // one-cycle end-of-packet pulse, full or short packet alike
    task automatic send_rx(input logic err, input logic [2:0] ep, input logic [6:0] cnt);
        rx_evt <= '{valid: 1'b1, err: err, ep: ep, count: cnt};
        @(posedge pclk);
        rx_evt <= '0;
        @(posedge pclk);
    endtask

    // host acknowledge of the packet just sent
    task automatic send_ack(input logic [2:0] ep);
        tx_ack_evt <= '{valid: 1'b1, ep: ep};
        @(posedge pclk);
        tx_ack_evt <= '0;
        @(posedge pclk);
    endtask

    // frame-start packet seen on the bus
    task automatic send_sof();
        sof_seen <= 1'b1;
        @(posedge pclk);
        sof_seen <= 1'b0;
        @(posedge pclk);
    endtask

    // hold a line state for n clock cycles
    task automatic hold_line(input logic dp, input logic dm, input int n);
        line <= '{dp: dp, dm: dm};
        repeat (n) @(posedge pclk);
    endtask
endmodule
